// File: ccg_pkg.sv
`default_nettype none
package ccg_pkg;
  localparam int CLK_MHZ   = 40;
  localparam int LOCK_US   = 100;
  localparam int LOCK_CYC  = LOCK_US * CLK_MHZ;
  localparam int LOCK_W    = 13;
  localparam int PEND_W    = 10;
  localparam int RTC_1K_DIV = 32;
  localparam int RTC_1HZ_DIV = 1024;
  // Main clock source codes
  localparam logic [2:0] MAIN_FAST   = 3'h0;
  localparam logic [2:0] MAIN_SYSPLL = 3'h1;
  localparam logic [2:0] MAIN_SYSOSC = 3'h2;
  localparam logic [2:0] MAIN_WDT    = 3'h3;
  localparam logic [2:0] MAIN_RTC32K = 3'h4;
  localparam int         MAIN_N      = 5;
  // PLL reference codes
  localparam logic       REF_FAST    = 1'h0;
  localparam logic       REF_SYSOSC  = 1'h1;
  // Observe pin codes
  localparam logic [2:0] OBS_FAST    = 3'h0;
  localparam logic [2:0] OBS_SYSOSC  = 3'h1;
  localparam logic [2:0] OBS_WDT     = 3'h2;
  localparam logic [2:0] OBS_RTC32K  = 3'h3;
  localparam logic [2:0] OBS_MAIN    = 3'h4;
  localparam logic [2:0] OBS_SYSPLL  = 3'h5;
  localparam logic [2:0] OBS_USBPLL  = 3'h6;
  localparam logic [2:0] OBS_SCTPLL  = 3'h7;
  localparam int         OBS_N       = 8;
  localparam logic [7:0] CPU_DIV_RST = 8'h01;
  typedef enum logic [1:0] {
    CCG_RUN   = 2'b01,
    CCG_SLEEP = 2'b10
  } ccg_pwr_t;
endpackage
`default_nettype wire

// File: ccg_top.sv
// Notes on behaviour
// - Reset or deep power-down wake selects the fast internal oscillator as main clock.
// - Fast internal oscillator may feed each PLL reference and the dividers.
// - System oscillator selectable as main clock directly or via system PLL.
// - Watchdog oscillator routes to main clock, watchdog clock and observe pin.
// - RTC oscillator gives 1 Hz and 1 kHz; 32 kHz selectable as main and observe.
// - Three identical PLLs: system, USB and asynchronous converter/timer clock.
// - Each PLL multiplies its reference by an integer from 1 to 32.
// - Post divider 2, 4, 8 or 16; software keeps the oscillator in range.
// - PLL output has 50 percent duty cycle.
// - After reset every PLL is unlocked; power-down and bypass follow the pll_power_down and pll_bypass inputs.
// - Observe pin selects any oscillator, any PLL or the main clock.
// - Per-peripheral gate bits stop each peripheral clock.
// - CPU clock divider, plus a separate divider for selected peripherals.
// - Sleep stops only the core clock; interrupt or reset restarts it.
// - Peripheral clocks keep running during sleep.
`default_nettype none

module ccg_sel_mux #(
  parameter int                 N   = 2,
  parameter int                 W   = 1,
  parameter logic [W-1:0]       RST = '0
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             force_rst,
  input  wire logic [W-1:0]     sel,
  input  wire logic [N-1:0]     ticks,
  output logic                  tick_r,
  output logic [W-1:0]          cur_r
);
  logic [W-1:0] cur_nxt;
  logic         tick_nxt;

  // Handover by sel waits for a quiet cycle of both sources, so no pulse is cut or doubled; force_rst switches at once
  always_comb
  begin
    cur_nxt  = cur_r;
    tick_nxt = ticks[cur_r];
    if (force_rst)
      cur_nxt = RST;
    else if ((sel != cur_r) && (int'(sel) < N) && !ticks[cur_r] && !ticks[sel])
      cur_nxt = sel;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cur_r  <= RST;
      tick_r <= 1'b0;
    end
    else
    begin
      cur_r  <= cur_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

module ccg_div #(
  parameter int                 W = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_tick,
  input  wire logic [W-1:0]     div,
  output logic                  tick_r
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         tick_nxt;

  // A divisor of zero holds the output quiet
  always_comb
  begin
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (div == '0)
      cnt_nxt = '0;
    else if (in_tick)
    begin
      if (cnt_r >= div - W'(1))
      begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

module ccg_pll (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             ref_tick,
  input  wire logic [4:0]       msel,
  input  wire logic [1:0]       psel,
  input  wire logic             pd,
  input  wire logic             bypass,
  output logic                  tick_r,
  output logic                  clk_r,
  output logic                  lock_r
);
  localparam int PW = ccg_pkg::PEND_W;
  localparam int LW = ccg_pkg::LOCK_W;
  logic [PW-1:0] pend_r;
  logic [PW-1:0] pend_nxt;
  logic [3:0]    half_r;
  logic [3:0]    half_nxt;
  logic [LW-1:0] lk_r;
  logic [LW-1:0] lk_nxt;
  logic          clk_nxt;
  logic          tick_nxt;
  logic          lock_nxt;
  logic          cco_ev;
  logic [3:0]    half_lim;
  logic [PW-1:0] mult;

  // Oscillator events are queued per reference edge and drained one per cycle;
  // the modelled rate is therefore capped at the system clock rate.
  always_comb
  begin
    mult     = PW'({1'b0, msel}) + PW'(1);
    half_lim = 4'h1 << psel;
    cco_ev   = (pend_r != '0) && !pd;
    pend_nxt = pend_r;
    if (pd)
      pend_nxt = '0;
    else
    begin
      if (cco_ev)
        pend_nxt = pend_nxt - PW'(1);
      if (ref_tick && (pend_nxt <= {PW{1'b1}} - mult))
        pend_nxt = pend_nxt + mult;
    end
    half_nxt = half_r;
    clk_nxt  = clk_r;
    tick_nxt = 1'b0;
    if (bypass)
    begin
      half_nxt = '0;
      tick_nxt = ref_tick;
      if (ref_tick)
        clk_nxt = ~clk_r;
    end
    else if (cco_ev)
    begin
      // Equal high and low halves give the even duty cycle
      if (half_r >= half_lim - 4'h1)
      begin
        half_nxt = '0;
        clk_nxt  = ~clk_r;
        tick_nxt = ~clk_r;
      end
      else
        half_nxt = half_r + 4'h1;
    end
    lk_nxt   = lk_r;
    if (pd)
      lk_nxt = '0;
    else if (lk_r < LW'(ccg_pkg::LOCK_CYC))
      lk_nxt = lk_r + LW'(1);
    lock_nxt = !pd && (lk_nxt == LW'(ccg_pkg::LOCK_CYC));
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pend_r <= '0;
      half_r <= '0;
      lk_r   <= '0;
      clk_r  <= 1'b0;
      tick_r <= 1'b0;
      lock_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      half_r <= half_nxt;
      lk_r   <= lk_nxt;
      clk_r  <= clk_nxt;
      tick_r <= tick_nxt;
      lock_r <= lock_nxt;
    end
  end
endmodule

module ccg_top #(
  parameter int                 NPERIPH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             dpd_wake,
  input  wire logic             fast_internal_osc_tick,
  input  wire logic             sys_osc_tick,
  input  wire logic             wdt_osc_tick,
  input  wire logic             rtc32k_tick,
  input  wire logic [2:0]       main_sel,
  input  wire logic [2:0]       observe_sel,
  input  wire logic [2:0]       pll_ref_sel,
  input  wire logic [14:0]      pll_mul,
  input  wire logic [5:0]       pll_post,
  input  wire logic [2:0]       pll_power_down,
  input  wire logic [2:0]       pll_bypass,
  input  wire logic [7:0]       cpu_div,
  input  wire logic [7:0]       periph_div,
  input  wire logic [NPERIPH-1:0] periph_gate,
  input  wire logic             sleep_req,
  input  wire logic             wake_irq,
  output logic                  core_clk_en,
  output logic [NPERIPH-1:0]    periph_clk_en,
  output logic                  periph_div_clk_en,
  output logic                  usb_clk_en,
  output logic                  async_clk_en,
  output logic                  wdt_clk_en,
  output logic                  rtc_1hz_en,
  output logic                  rtc_1khz_en,
  output logic                  clock_observe_pin,
  output logic [2:0]            pll_locked,
  output logic                  sleeping
);
  logic [2:0]         ref_tick;
  logic [2:0]         pll_tick;
  logic [2:0]         pll_clk;
  logic [2:0]         pll_lock;
  logic               main_tick;
  logic               cpu_tick;
  logic               pdiv_tick;
  logic               obs_tick;
  logic               rtc_1k;
  logic               rtc_1hz;
  logic               obs_pin_nxt;
  logic               obs_pin_r;
  ccg_pkg::ccg_pwr_t  pwr_r;
  ccg_pkg::ccg_pwr_t  pwr_nxt;
  logic               core_nxt;
  logic [NPERIPH-1:0] per_nxt;

  // 0 system, 1 USB, 2 asynchronous converter and timer clock
  for (genvar i = 0; i < 3; i++)
  begin : g_pll
    ccg_sel_mux #(.N(2), .W(1), .RST(ccg_pkg::REF_FAST)) u_ref (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .force_rst (1'b0),
      .sel       (pll_ref_sel[i]),
      .ticks     ({sys_osc_tick, fast_internal_osc_tick}),
      .tick_r    (ref_tick[i]),
      .cur_r     ()
    );
    ccg_pll u_pll (
      .ref_clk  (ref_clk),
      .reset    (reset),
      .ref_tick (ref_tick[i]),
      .msel     (pll_mul[5*i +: 5]),
      .psel     (pll_post[2*i +: 2]),
      .pd       (pll_power_down[i]),
      .bypass   (pll_bypass[i]),
      .tick_r   (pll_tick[i]),
      .clk_r    (pll_clk[i]),
      .lock_r   (pll_lock[i])
    );
  end

  ccg_sel_mux #(.N(ccg_pkg::MAIN_N), .W(3), .RST(ccg_pkg::MAIN_FAST)) u_main (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .force_rst (dpd_wake),
    .sel       (main_sel),
    .ticks     ({rtc32k_tick, wdt_osc_tick, sys_osc_tick, pll_tick[0],
                 fast_internal_osc_tick}),
    .tick_r    (main_tick),
    .cur_r     ()
  );

  ccg_sel_mux #(.N(ccg_pkg::OBS_N), .W(3), .RST(ccg_pkg::OBS_FAST)) u_obs (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .force_rst (1'b0),
    .sel       (observe_sel),
    .ticks     ({pll_tick, main_tick, rtc32k_tick, wdt_osc_tick, sys_osc_tick,
                 fast_internal_osc_tick}),
    .tick_r    (obs_tick),
    .cur_r     ()
  );

  ccg_div #(.W(8)) u_cpu_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .in_tick (main_tick),
    .div     (cpu_div),
    .tick_r  (cpu_tick)
  );

  ccg_div #(.W(8)) u_per_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .in_tick (main_tick),
    .div     (periph_div),
    .tick_r  (pdiv_tick)
  );

  ccg_div #(.W(6)) u_rtc_1k (
    .ref_clk (ref_clk),
    .reset   (reset),
    .in_tick (rtc32k_tick),
    .div     (6'(ccg_pkg::RTC_1K_DIV)),
    .tick_r  (rtc_1k)
  );

  ccg_div #(.W(11)) u_rtc_1hz (
    .ref_clk (ref_clk),
    .reset   (reset),
    .in_tick (rtc_1k),
    .div     (11'(ccg_pkg::RTC_1HZ_DIV)),
    .tick_r  (rtc_1hz)
  );

  // Interrupt wins over a same-cycle sleep request so no wake event is lost
  always_comb
  begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ccg_pkg::CCG_RUN:
        if (sleep_req && !wake_irq)
          pwr_nxt = ccg_pkg::CCG_SLEEP;
      ccg_pkg::CCG_SLEEP:
        if (wake_irq)
          pwr_nxt = ccg_pkg::CCG_RUN;
      default:
        pwr_nxt = ccg_pkg::CCG_RUN;
    endcase
    core_nxt    = cpu_tick && (pwr_r == ccg_pkg::CCG_RUN);
    per_nxt     = {NPERIPH{main_tick}} & ~periph_gate;
    obs_pin_nxt = obs_pin_r;
    if (obs_tick)
      obs_pin_nxt = ~obs_pin_r;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pwr_r             <= ccg_pkg::CCG_RUN;
      obs_pin_r         <= 1'b0;
      core_clk_en       <= 1'b0;
      periph_clk_en     <= '0;
      periph_div_clk_en <= 1'b0;
      usb_clk_en        <= 1'b0;
      async_clk_en      <= 1'b0;
      wdt_clk_en        <= 1'b0;
      rtc_1hz_en        <= 1'b0;
      rtc_1khz_en       <= 1'b0;
      clock_observe_pin <= 1'b0;
      pll_locked        <= '0;
      sleeping          <= 1'b0;
    end
    else
    begin
      pwr_r             <= pwr_nxt;
      obs_pin_r         <= obs_pin_nxt;
      core_clk_en       <= core_nxt;
      periph_clk_en     <= per_nxt;
      periph_div_clk_en <= pdiv_tick;
      usb_clk_en        <= pll_tick[1];
      async_clk_en      <= pll_tick[2];
      wdt_clk_en        <= wdt_osc_tick;
      rtc_1hz_en        <= rtc_1hz;
      rtc_1khz_en       <= rtc_1k;
      clock_observe_pin <= obs_pin_r;
      pll_locked        <= pll_lock;
      sleeping          <= (pwr_nxt == ccg_pkg::CCG_SLEEP);
    end
  end
endmodule
`default_nettype wire

// File: ccg_props.sv
`default_nettype none
module ccg_props #(
  parameter int NPERIPH = 16
) (
  input wire logic               ref_clk,
  input wire logic               reset,
  input wire logic               wdt_osc_tick,
  input wire logic               sleep_req,
  input wire logic               wake_irq,
  input wire logic [2:0]         pll_power_down,
  input wire logic [NPERIPH-1:0] periph_gate,
  input wire logic               core_clk_en,
  input wire logic [NPERIPH-1:0] periph_clk_en,
  input wire logic               wdt_clk_en,
  input wire logic [2:0]         pll_locked,
  input wire logic               sleeping
);
  localparam int LCK = ccg_pkg::LOCK_CYC;
  logic [15:0] lk_r;
  logic [15:0] lk_nxt;
  // Saturates so a long run never wraps back into the early window
  always_comb lk_nxt = (reset || pll_power_down[0]) ? 16'h0 : lk_r + {15'h0, lk_r != 16'hFFFF};
  always_ff @(posedge ref_clk) lk_r <= lk_nxt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_asleep; sleeping [*3]; endsequence
  sequence s_off; pll_power_down[0] [*2]; endsequence
  property p_sleep_in; !sleeping && sleep_req && !wake_irq |=> sleeping; endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
  property p_wake; sleeping && wake_irq |=> !sleeping; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_core_stop; s_asleep |-> !core_clk_en; endproperty
  a_core_stop: assert property (p_core_stop) else $error("core ran in sleep");
  property p_gate; (periph_clk_en & $past(periph_gate)) == '0; endproperty
  a_gate: assert property (p_gate) else $error("gated clock ran");
  property p_wdt; !$past(reset) |-> wdt_clk_en == $past(wdt_osc_tick); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clock wrong");
  property p_lock_early; pll_locked[0] |-> lk_r >= LCK - 4; endproperty
  a_lock_early: assert property (p_lock_early) else $error("lock too early");
  property p_lock_late; lk_r == LCK + 8 |-> pll_locked[0]; endproperty
  a_lock_late: assert property (p_lock_late) else $error("lock too late");
  property p_off; s_off |=> !pll_locked[0]; endproperty
  a_off: assert property (p_off) else $error("locked while off");
  // Sources never tick on adjacent cycles here, so a double pulse is a runt
  property p_glitch; periph_clk_en[0] |=> !periph_clk_en[0]; endproperty
  a_glitch: assert property (p_glitch) else $error("runt main pulse");
endmodule
bind ccg_top ccg_props #(.NPERIPH(NPERIPH)) ccg_props_inst (.ref_clk, .reset, .wdt_osc_tick,
  .sleep_req, .wake_irq, .pll_power_down, .periph_gate, .core_clk_en, .periph_clk_en,
  .wdt_clk_en, .pll_locked, .sleeping);
`default_nettype wire

// File: tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] ms; logic [7:0] cd; logic [2:0] os; int mp; int op;} ccg_row_t;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        dpd_wake = 1'b0;
  logic        fast_internal_osc_tick = 1'b0;
  logic        sys_osc_tick = 1'b0;
  logic        wdt_osc_tick = 1'b0;
  logic        rtc32k_tick = 1'b0;
  logic [2:0]  main_sel = 3'h5;
  logic [2:0]  observe_sel = 3'h0;
  logic [2:0]  pll_ref_sel = 3'h0;
  logic [14:0] pll_mul = 15'h0;
  logic [5:0]  pll_post = 6'h0;
  logic [2:0]  pll_power_down = 3'h7;
  logic [2:0]  pll_bypass = 3'h7;
  logic [7:0]  cpu_div = 8'h01;
  logic [7:0]  periph_div = 8'h02;
  logic [15:0] periph_gate = 16'h0;
  logic        sleep_req = 1'b0;
  logic        wake_irq = 1'b0;
  logic        core_clk_en, periph_div_clk_en, usb_clk_en, async_clk_en, wdt_clk_en;
  logic        rtc_1hz_en, rtc_1khz_en, clock_observe_pin, sleeping, obs_q;
  logic [15:0] periph_clk_en;
  logic [2:0]  pll_locked;
  logic [9:0]  ev;
  int          n [10];
  int          tc = 0;
  int          checks = 0;
  int          err_total = 0;
  ccg_row_t    rows [8] = '{
    '{ccg_pkg::MAIN_FAST, 8'h00, ccg_pkg::OBS_USBPLL, 2, 2},
    '{ccg_pkg::MAIN_FAST, 8'h01, ccg_pkg::OBS_FAST, 2, 2},
    '{ccg_pkg::MAIN_SYSOSC, 8'h01, ccg_pkg::OBS_WDT, 3, 5},
    '{ccg_pkg::MAIN_RTC32K, 8'h01, ccg_pkg::OBS_MAIN, 4, 4},
    '{ccg_pkg::MAIN_SYSPLL, 8'h02, ccg_pkg::OBS_SYSOSC, 2, 3},
    '{ccg_pkg::MAIN_WDT, 8'h03, ccg_pkg::OBS_RTC32K, 5, 4},
    '{ccg_pkg::MAIN_SYSOSC, 8'h04, ccg_pkg::OBS_SYSPLL, 3, 2},
    '{ccg_pkg::MAIN_RTC32K, 8'h05, ccg_pkg::OBS_SCTPLL, 4, 2}};
  ccg_top #(.NPERIPH(16)) ccg_top_inst (.ref_clk, .reset, .dpd_wake, .fast_internal_osc_tick,
    .sys_osc_tick, .wdt_osc_tick, .rtc32k_tick, .main_sel, .observe_sel, .pll_ref_sel, .pll_mul,
    .pll_post, .pll_power_down, .pll_bypass, .cpu_div, .periph_div, .periph_gate, .sleep_req,
    .wake_irq, .core_clk_en, .periph_clk_en, .periph_div_clk_en, .usb_clk_en, .async_clk_en,
    .wdt_clk_en, .rtc_1hz_en, .rtc_1khz_en, .clock_observe_pin, .pll_locked, .sleeping);
  always #12.5 ref_clk = ~ref_clk;
  // Periods 2, 3, 5 and 4 cycles; 60 keeps every phase repeating
  always @(posedge ref_clk)
  begin
    tc <= (tc + 1) % 60;
    fast_internal_osc_tick <= (tc % 2 == 0);
    sys_osc_tick <= (tc % 3 == 0);
    wdt_osc_tick <= (tc % 5 == 0);
    rtc32k_tick <= (tc % 4 == 0);
  end
  assign ev = {rtc_1hz_en, rtc_1khz_en, clock_observe_pin !== obs_q, wdt_clk_en, async_clk_en,
    usb_clk_en, periph_div_clk_en, periph_clk_en[1:0], core_clk_en};
  always @(negedge ref_clk)
  begin
    for (int i = 0; i < 10; i++)
      if (ev[i] === 1'b1)
        n[i]++;
    obs_q = clock_observe_pin;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %0d expected %0d", $time, seen, exp);
    end
  endtask
  // Window lengths are multiples of every period checked in them, so those counts are phase-free
  task automatic win(input int len);
    repeat (40) @(posedge ref_clk);
    n = '{default: 0};
    repeat (len) @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    repeat (19) @(posedge ref_clk);
    chk({sleeping, core_clk_en, pll_locked}, 0);
    @(posedge ref_clk);
    reset <= 1'b0;
    win(240);
    chk(n[1], 120);
    for (int i = 0; i < 8; i++)
    begin
      main_sel <= rows[i].ms;
      cpu_div <= rows[i].cd;
      observe_sel <= rows[i].os;
      win(240);
      chk(n[0], rows[i].cd == 0 ? 0 : 240 / (rows[i].mp * rows[i].cd));
      chk(n[1], 240 / rows[i].mp);
      chk(n[3], 240 / (rows[i].mp * 2));
      chk(n[7], 240 / rows[i].op);
      chk(n[4], 120);
      chk(n[5], 120);
      chk(n[6], 48);
    end
    reset <= 1'b1;
    main_sel <= ccg_pkg::MAIN_SYSOSC;
    cpu_div <= 8'h01;
    repeat (20) @(posedge ref_clk);
    chk({sleeping, core_clk_en, pll_locked, periph_clk_en}, 0);
    reset <= 1'b0;
    win(240);
    chk(n[1], 80);
    main_sel <= 3'h7;
    dpd_wake <= 1'b1;
    @(posedge ref_clk);
    dpd_wake <= 1'b0;
    win(240);
    chk(n[1], 120);
    periph_gate <= 16'h0002;
    pll_ref_sel <= 3'h2;
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    win(240);
    chk(n[0], 0);
    chk(n[1], 120);
    chk(n[2], 0);
    chk(n[4], 80);
    chk(sleeping, 1);
    wake_irq <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b1;
    @(posedge ref_clk);
    sleep_req <= 1'b0;
    wake_irq <= 1'b0;
    win(240);
    chk(n[0], 120);
    chk(sleeping, 0);
    pll_power_down <= 3'h6;
    repeat (3980) @(posedge ref_clk);
    chk(pll_locked[0], 0);
    repeat (40) @(posedge ref_clk);
    chk(pll_locked[0], 1);
    pll_bypass <= 3'h6;
    pll_mul <= 15'h0001;
    main_sel <= ccg_pkg::MAIN_SYSPLL;
    win(240);
    chk(n[1], 120);
    pll_mul <= 15'h0;
    pll_post <= 6'h01;
    win(1280);
    chk(n[1], 160);
    chk(n[8], 10);
    // The 1 Hz enable is far slower than any window here, so it must stay quiet
    chk(n[9], 0);
    give_verdict();
  end
endmodule
`default_nettype wire
